// *** dmrz_mode_register_zero.sv ***
// Mode register zero capture and field decode, driven by mode set commands.
`timescale 1ns/10ps
`default_nettype none
`include "dmrz_consts.svh"

module dmrz_mode_register_zero
  import dmrz_pkg::*;
#(
  parameter int SUPPORT_A13 = 0,
  parameter int SUPPORT_A12 = 0,
  parameter int TRP_W = 6
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Mode set command from the controller logic.
  input wire logic mrs_cmd,
  input wire logic [1:0] bank_group,
  input wire logic [1:0] bank_addr,
  input wire logic [17:0] addr,
  // Precharge period in cycles.
  input wire logic [TRP_W-1:0] precharge_period,
  // Stored register and other register selection.
  output logic [17:0] mode_register_zero_r,
  output logic other_write_r,
  output logic [2:0] other_sel_r,
  // Decoded fields.
  output logic [4:0] wr_cycles_r,
  output logic [3:0] read_to_precharge_cycles_r,
  output logic wr_reserved_r,
  output logic [4:0] cas_code_r,
  output logic dll_reset_r,
  output logic test_mode_bit_r,
  output logic interleave_r,
  output dmrz_burst_t burst_mode_r,
  output logic burst_reserved_r,
  output logic [TRP_W:0] autoprecharge_write_to_activate_delay_r
);

  // =====================================================================
  // Parameter checks
  initial begin
    // The delay sum must hold a five-bit write recovery value, so TRP_W is at least four.
    if (TRP_W < 4 || TRP_W > 8 || SUPPORT_A13 > 1 || SUPPORT_A12 > 1 ||
        SUPPORT_A13 < 0 || SUPPORT_A12 < 0) begin
      $error("Unsupported parameter value for the mode register zero block.");
    end
  end

  // =====================================================================
  // Decode functions
  // Write recovery cycles for a field code; reserved codes return zero.
  function automatic logic [4:0] wr_of(input logic [3:0] code);
    case (code)
      4'h0: wr_of = 5'h0A;
      4'h1: wr_of = 5'h0C;
      4'h2: wr_of = 5'h0E;
      4'h3: wr_of = 5'h10;
      4'h4: wr_of = 5'h12;
      4'h5: wr_of = 5'h14;
      4'h6: wr_of = 5'h18;
      4'h7: wr_of = 5'h16;
      4'h8: wr_of = 5'h1A;
      default: wr_of = 5'h00;
    endcase
  endfunction : wr_of

  // Read-to-precharge cycles are half of the write recovery cycles.
  function automatic logic [3:0] rtp_of(input logic [3:0] code);
    logic [4:0] wr;
    wr = wr_of(code);
    rtp_of = wr[4:1];
  endfunction : rtp_of

  // =====================================================================
  // Command decode
  logic [2:0] sel;
  logic load_mr0;
  logic [3:0] wr_code_nxt;
  logic [4:0] cas_code_nxt;

  // Select gathers bank group bit 0 over the two bank address bits.
  assign sel = {bank_group[0], bank_addr};
  assign load_mr0 = mrs_cmd && (sel == `DMRZ_SEL_MR0);
  // The optional top bits are forced low when unsupported.
  assign wr_code_nxt = {addr[`DMRZ_POS_WR3] & (SUPPORT_A13 != 0),
                        addr[`DMRZ_POS_WR2], addr[`DMRZ_POS_WR1],
                        addr[`DMRZ_POS_WR0]};
  assign cas_code_nxt = {addr[`DMRZ_POS_CL4] & (SUPPORT_A12 != 0),
                         addr[`DMRZ_POS_CL3], addr[`DMRZ_POS_CL2],
                         addr[`DMRZ_POS_CL1], addr[`DMRZ_POS_CL0]};

  // =====================================================================
  // Register storage
  // Stores the whole address word; reserved bits are kept as given.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_register_zero_r <= `DMRZ_MR0_RESET;
    end else if (load_mr0) begin
      mode_register_zero_r <= addr;
    end
  end

  // Flags a write aimed at one of the other six mode registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      other_write_r <= 1'b0;
      other_sel_r <= 3'h0;
    end else begin
      other_write_r <= mrs_cmd && (sel != `DMRZ_SEL_MR0) &&
                       (sel != `DMRZ_SEL_CTRL_WORD);
      if (mrs_cmd && sel != `DMRZ_SEL_CTRL_WORD) begin
        other_sel_r <= sel;
      end
    end
  end

  // =====================================================================
  // Write recovery and read-to-precharge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_cycles_r <= `DMRZ_WR_RESET;
      read_to_precharge_cycles_r <= `DMRZ_RTP_RESET;
      wr_reserved_r <= 1'b0;
    end else if (load_mr0) begin
      wr_cycles_r <= wr_of(wr_code_nxt);
      read_to_precharge_cycles_r <= rtp_of(wr_code_nxt);
      wr_reserved_r <= wr_code_nxt > `DMRZ_WR_LAST_CODE;
    end
  end

  // Auto-precharge write to activate delay follows one cycle behind.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      autoprecharge_write_to_activate_delay_r <= '0;
    end else begin
      autoprecharge_write_to_activate_delay_r <=
        (TRP_W+1)'(wr_cycles_r) + (TRP_W+1)'(precharge_period);
    end
  end

  // =====================================================================
  // CAS latency, DLL reset, test mode and burst fields
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cas_code_r <= 5'h00;
      test_mode_bit_r <= 1'b0;
      interleave_r <= 1'b0;
    end else if (load_mr0) begin
      cas_code_r <= cas_code_nxt;
      test_mode_bit_r <= addr[`DMRZ_POS_TM];
      interleave_r <= addr[`DMRZ_POS_BT];
    end
  end

  // DLL reset is a one-cycle start pulse.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dll_reset_r <= 1'b0;
    end else begin
      dll_reset_r <= load_mr0 && addr[`DMRZ_POS_DLL];
    end
  end

  // Burst length mode and its reserved flag.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      burst_mode_r <= DMRZ_FIXED_BURST_EIGHT;
      burst_reserved_r <= 1'b0;
    end else if (load_mr0) begin
      burst_mode_r <= dmrz_burst_t'(addr[`DMRZ_POS_BL_HI:`DMRZ_POS_BL_LO]);
      burst_reserved_r <= addr[`DMRZ_POS_BL_HI:`DMRZ_POS_BL_LO] ==
                          `DMRZ_BL_RESERVED;
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_word;
    mrs_cmd && sel == `DMRZ_SEL_CTRL_WORD;
  endsequence

  sequence s_mr0_load;
    mrs_cmd && sel == `DMRZ_SEL_MR0;
  endsequence

  property p_ignore_ctrl_word;
    s_ctrl_word |=> $stable(mode_register_zero_r) && !other_write_r && !dll_reset_r;
  endproperty
  a_ignore_ctrl_word: assert property (p_ignore_ctrl_word)
    else $error("Control word select changed the block state.");

  property p_mr0_loads;
    s_mr0_load |=> mode_register_zero_r == $past(addr) && !other_write_r;
  endproperty
  a_mr0_loads: assert property (p_mr0_loads)
    else $error("Mode register zero did not load the address word.");

  property p_other_sel;
    mrs_cmd && sel != `DMRZ_SEL_MR0 && sel != `DMRZ_SEL_CTRL_WORD |=>
      other_write_r && other_sel_r == $past(sel) && $stable(mode_register_zero_r);
  endproperty
  a_other_sel: assert property (p_other_sel)
    else $error("Other register write was not flagged.");

  property p_wr_code6;
    s_mr0_load ##0 wr_code_nxt == 4'h6 |=>
      wr_cycles_r == 5'h18 && read_to_precharge_cycles_r == 4'hC ##1
      autoprecharge_write_to_activate_delay_r ==
        (TRP_W+1)'(5'h18) + (TRP_W+1)'($past(precharge_period));
  endproperty
  a_wr_code6: assert property (p_wr_code6)
    else $error("Write recovery code six decoded wrongly.");

  property p_wr_last;
    s_mr0_load ##0 wr_code_nxt == `DMRZ_WR_LAST_CODE |=>
      wr_cycles_r == 5'h1A && read_to_precharge_cycles_r == 4'hD && !wr_reserved_r;
  endproperty
  a_wr_last: assert property (p_wr_last)
    else $error("Write recovery code eight decoded wrongly.");

  property p_a13_optional;
    s_mr0_load |=> wr_reserved_r ==
      ((SUPPORT_A13 != 0) && $past(addr[`DMRZ_POS_WR3]) &&
       ($past(addr[`DMRZ_POS_WR2:`DMRZ_POS_WR0]) != 3'h0));
  endproperty
  a_a13_optional: assert property (p_a13_optional)
    else $error("Unsupported top write recovery bit was honoured.");

  property p_dll_pulse;
    s_mr0_load ##0 addr[`DMRZ_POS_DLL] |=> dll_reset_r ##1 (dll_reset_r == $past(load_mr0 && addr[`DMRZ_POS_DLL]));
  endproperty
  a_dll_pulse: assert property (p_dll_pulse)
    else $error("DLL reset pulse wrong.");

  property p_dll_quiet;
    !(load_mr0 && addr[`DMRZ_POS_DLL]) |=> !dll_reset_r;
  endproperty
  a_dll_quiet: assert property (p_dll_quiet)
    else $error("DLL reset started without a request.");

  property p_burst;
    s_mr0_load |=> burst_reserved_r == ($past(addr[1:0]) == `DMRZ_BL_RESERVED) &&
      burst_mode_r == dmrz_burst_t'($past(addr[1:0]));
  endproperty
  a_burst: assert property (p_burst)
    else $error("Burst length field decoded wrongly.");

  property p_cas_mode;
    s_mr0_load |=> cas_code_r[3:0] == {$past(addr[6]), $past(addr[5]), $past(addr[4]),
      $past(addr[2])} && test_mode_bit_r == $past(addr[7]) &&
      interleave_r == $past(addr[3]);
  endproperty
  a_cas_mode: assert property (p_cas_mode)
    else $error("CAS code or mode bits captured wrongly.");

endmodule : dmrz_mode_register_zero
`default_nettype wire

// *** dmrz_consts.svh ***
// Constants for the mode register zero decode block.
// What this block does
// - The three select bits pick one of seven mode registers and a select of all ones is ignored.
// - The write recovery field decodes codes 0 to 8 to fixed recovery and read-to-precharge cycles.
// - Programmed write recovery plus the precharge period forms the auto-precharge delay.
// - Address bit 13 as top write recovery bit is optional and only the low three bits must work.
// - Burst length decodes as fixed eight, on the fly chop, fixed chop four, or reserved.
// - The CAS latency code is gathered from address bits 12, 6, 5, 4 and 2, bit 12 optional.
`ifndef DMRZ_CONSTS_SVH
`define DMRZ_CONSTS_SVH

// =====================================================================
// Select codes
`define DMRZ_SEL_MR0 3'h0
`define DMRZ_SEL_CTRL_WORD 3'h7

// =====================================================================
// Address field positions
`define DMRZ_POS_BL_LO 0
`define DMRZ_POS_BL_HI 1
`define DMRZ_POS_CL0 2
`define DMRZ_POS_BT 3
`define DMRZ_POS_CL1 4
`define DMRZ_POS_CL2 5
`define DMRZ_POS_CL3 6
`define DMRZ_POS_TM 7
`define DMRZ_POS_DLL 8
`define DMRZ_POS_WR0 9
`define DMRZ_POS_WR1 10
`define DMRZ_POS_WR2 11
`define DMRZ_POS_CL4 12
`define DMRZ_POS_WR3 13
`define DMRZ_POS_RSV 17

// =====================================================================
// Reset values and codes
`define DMRZ_MR0_RESET 18'h00000
`define DMRZ_WR_RESET 5'h0A
`define DMRZ_RTP_RESET 4'h5
`define DMRZ_WR_LAST_CODE 4'h8
`define DMRZ_BL_RESERVED 2'h3

`endif

// *** dmrz_pkg.sv ***
// Types shared by the mode register zero decode block.
package dmrz_pkg;

  // Burst length modes carried by the two low address bits.
  typedef enum logic [1:0] {
    DMRZ_FIXED_BURST_EIGHT,
    DMRZ_BURST_CHOP_ON_THE_FLY,
    DMRZ_FIXED_BURST_CHOP_FOUR,
    DMRZ_BURST_RESERVED
  } dmrz_burst_t;

endpackage : dmrz_pkg

// *** dmrz_ctrl_model.sv ***
// Behavioural memory controller that issues mode set commands.
`timescale 1ns/10ps
`default_nettype none

module dmrz_ctrl_model #(
  parameter int GAP = 4
) (
  // Clock.
  input wire logic core_clk,
  // Command pins toward the device.
  output logic mrs_cmd,
  output logic [1:0] bank_group,
  output logic [1:0] bank_addr,
  output logic [17:0] addr
);
  // Pins start idle with no command.
  initial begin
    mrs_cmd = 1'b0;
    bank_group = 2'h0;
    bank_addr = 2'h0;
    addr = 18'h00000;
  end

  // Waits the cycle time, then issues one command for exactly one cycle.
  task automatic send(input logic [2:0] sel, input logic [17:0] a);
    repeat (GAP) @(posedge core_clk);
    #1;
    mrs_cmd = 1'b1;
    bank_group = {1'b0, sel[2]};
    bank_addr = sel[1:0];
    addr = {1'b0, a[16:0]};
    @(posedge core_clk);
    #1;
    // Outside a command the pins show the inverse of the last value.
    mrs_cmd = 1'b0;
    bank_group = ~bank_group;
    bank_addr = ~bank_addr;
    addr = ~addr;
  endtask : send

endmodule : dmrz_ctrl_model
`default_nettype wire

// *** dmrz_testbench.sv ***
// Self-checking testbench for the mode register zero decode block.
`timescale 1ns/10ps
`default_nettype none

module testbench
  import dmrz_pkg::*;
;
  // ======================================================
  // Signals
  logic core_clk;
  logic rst_n;
  logic [5:0] precharge_period;
  logic mrs_cmd;
  logic [1:0] bank_group;
  logic [1:0] bank_addr;
  logic [17:0] addr;
  logic [17:0] word;
  logic other_write, wr_rsv, dll, tm, ilv, bl_rsv;
  logic [2:0] other_sel;
  logic [4:0] wr, cas;
  logic [3:0] read_to_precharge_cycles;
  dmrz_burst_t bmode;
  logic [6:0] dal;
  int errors = 0;
  int total_checks = 0;
  logic [4:0] wr_tab [0:8] = '{5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14, 5'h18, 5'h16, 5'h1A};
  logic [3:0] rtp_tab [0:8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hB, 4'hD};

  // ======================================================
  // Instances
  dmrz_ctrl_model dmrz_ctrl_model_inst (.core_clk(core_clk), .mrs_cmd(mrs_cmd),
    .bank_group(bank_group), .bank_addr(bank_addr), .addr(addr));
  dmrz_mode_register_zero #(.SUPPORT_A13(1), .SUPPORT_A12(1), .TRP_W(6))
    dmrz_mode_register_zero_inst (.core_clk(core_clk), .rst_n(rst_n), .mrs_cmd(mrs_cmd),
    .bank_group(bank_group), .bank_addr(bank_addr), .addr(addr),
    .precharge_period(precharge_period), .mode_register_zero_r(word),
    .other_write_r(other_write), .other_sel_r(other_sel), .wr_cycles_r(wr),
    .read_to_precharge_cycles_r(read_to_precharge_cycles), .wr_reserved_r(wr_rsv), .cas_code_r(cas),
    .dll_reset_r(dll), .test_mode_bit_r(tm), .interleave_r(ilv), .burst_mode_r(bmode),
    .burst_reserved_r(bl_rsv), .autoprecharge_write_to_activate_delay_r(dal));

  // The clock toggles every half period of 10 ns.
  always #10 core_clk = ~core_clk;

  // ======================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Every write recovery code, the reserved ones included.
  task automatic test_wr();
    logic [17:0] a;
    logic [4:0] ew;
    // Codes above eight step outside the controller's duty on purpose to probe the flag.
    for (int c = 0; c < 16; c++) begin
      a = 18'h00000;
      a[13] = c[3];
      a[11:9] = c[2:0];
      precharge_period = 6'h0A + 6'(c);
      // Every legal code programs at least the ten-cycle recovery floor.
      ew = (c <= 8) ? wr_tab[c] : 5'h00;
      dmrz_ctrl_model_inst.send(3'h0, a);
      check("wr", wr, ew);
      check("rtp", read_to_precharge_cycles, (c <= 8) ? rtp_tab[c] : 4'h0);
      check("wr_rsv", wr_rsv, c > 8);
      @(posedge core_clk);
      #1;
      check("dal", dal, ew + precharge_period);
    end
  endtask : test_wr

  // Every burst code with the other single-bit fields and the latency code.
  task automatic test_fields();
    logic [17:0] a;
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      a = {5'h00, b[1], 3'h0, b[0], b[1], b[0], ~b[0], b[1], b[0], 1'b1, b};
      dmrz_ctrl_model_inst.send(3'h0, a);
      check("word", word, a);
      check("burst", bmode, b);
      check("bl_rsv", bl_rsv, b == 2'h3);
      check("cas", cas, {b[1], b[0], ~b[0], b[1], 1'b1});
      check("ilv", ilv, b[0]);
      check("tm", tm, b[1]);
      check("dll", dll, b[0]);
      @(posedge core_clk);
      #1;
      check("dll_end", dll, 1'b0);
    end
  endtask : test_fields

  // Selects one to seven never touch the stored word; seven is ignored outright.
  task automatic test_select();
    dmrz_ctrl_model_inst.send(3'h0, 18'h0A5A5);
    for (int s = 1; s < 8; s++) begin
      dmrz_ctrl_model_inst.send(s[2:0], 18'h15555);
      check("other_write", other_write, s < 7);
      check("other_sel", other_sel, (s < 7) ? s : 6);
      check("word_kept", word, 18'h0A5A5);
    end
  endtask : test_select

  // ======================================================
  // Main sequence: reset, reset values, then the scenarios.
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    precharge_period = 6'h16;
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check("rst_word", word, 18'h00000);
    check("rst_wr", wr, 5'h0A);
    check("rst_rtp", read_to_precharge_cycles, 4'h5);
    @(posedge core_clk);
    #1;
    check("rst_dal", dal, 7'h20);
    test_wr();
    test_fields();
    test_select();
    give_verdict();
  end

  // Watchdog cuts a hang short well beyond the expected run time.
  initial begin
    #100000;
    errors++;
    give_verdict();
  end

endmodule : testbench
`default_nettype wire
